// ===== hdl/host_shared_memory_bridge.sv
`timescale 1ns/10ps
`default_nettype none
`include "hsm_bridge_defines.svh"
module host_shared_memory_bridge #(
  parameter int HA_W = 20
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  input  wire logic            i_host_mem_read_n,
  input  wire logic            i_host_mem_write_n,
  input  wire logic            i_host_mem_select_n,
  input  wire logic            i_host_io_read_n,
  input  wire logic            i_host_io_write_n,
  input  wire logic            i_host_addr_enable,
  input  wire logic [HA_W-1:0] i_host_addr,
  input  wire logic [7:0]      i_host_data,
  output logic      [7:0]      o_host_data,
  output logic                 o_host_data_oe,
  output logic                 o_host_channel_ready,
  output logic                 o_host_reset_out_n,
  input  wire logic            i_shared_memory_strap,
  input  wire logic            i_host_reset_mode_strap,
  input  wire logic            i_host_device_enable_strap,
  input  wire logic            i_active_mode,
  input  wire logic            i_shared_mem_enable,
  input  wire logic            i_rom_shadow_off,
  output logic                 o_rom_shadow_on,
  output logic                 o_share_enabled,
  output logic                 o_core_bus_req,
  input  wire logic            i_core_bus_gnt,
  input  wire logic            i_mem_done,
  input  wire logic [15:0]     i_mem_rdata,
  output logic      [HA_W-1:0] o_mem_addr,
  output logic      [1:0]      o_mem_be,
  output logic                 o_mem_write,
  output logic      [15:0]     o_mem_wdata,
  input  wire logic            i_rtc_core_owner_lock,
  input  wire logic            i_rtc_memory_release,
  input  wire logic            i_rtc_cmos_lock_set,
  output logic                 o_rtc_cmos_locked,
  input  wire logic            i_rtc_dev_en_wr,
  input  wire logic            i_rtc_dev_en_val,
  output logic                 o_rtc_dev_enabled,
  input  wire logic            i_core_rtc_wr,
  input  wire logic            i_core_rtc_rd,
  input  wire logic            i_core_rtc_sel,
  input  wire logic [7:0]      i_core_rtc_wdata,
  output logic      [7:0]      o_core_rtc_rdata
);
  localparam int SW = 9 + HA_W + 8;

  generate
    if (HA_W < 16) begin : g_bad
      $error("Host address must cover the I/O ports.");
    end
  endgenerate

  typedef struct packed {
    hsm_bridge_pkg::mem_state_type st;
    logic [1:0]                    cnt;
    logic                          strap_done;
    logic                          share_en;
    logic                          hrst_mode;
    logic                          rtc_dev_en;
    logic                          ready;
    logic                          rst_out_n;
    logic                          req;
    logic                          mwr;
    logic [HA_W-1:0]               addr;
    logic [1:0]                    be;
    logic [7:0]                    wbuf;
    logic [7:0]                    hdata;
    logic                          hoe;
    logic                          iow_prev;
    logic [7:0]                    iodat;
    logic                          io_idx;
    logic                          io_dat;
    logic [7:0]                    index;
    logic                          cmos_lock;
    logic [7:0]                    crd;
    logic                          shadow;
  } state_type;

  state_type q;
  state_type d;

  // ****************************************************************
  // Pin synchronisers and decode
  // ****************************************************************
  logic [SW-1:0]   sv;
  logic            s_mrd_n;
  logic            s_mwr_n;
  logic            s_mcs_n;
  logic            s_ior_n;
  logic            s_iow_n;
  logic            s_aen;
  logic            s_shared_memory_strap;
  logic            s_host_reset_mode_strap;
  logic            s_host_device_enable_strap;
  logic [HA_W-1:0] s_addr;
  logic [7:0]      s_data;
  logic [7:0]      ram_rdata;
  logic [7:0]      ram_wdata;
  logic            ram_we;
  logic            mem_cmd;
  logic            can_go;
  logic            h_idx;
  logic            h_dat;
  logic            core_ok;
  logic            host_ok;
  logic            host_addr_bit0;

  bit_sync #(
    .WIDTH (SW)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_host_mem_read_n, i_host_mem_write_n,
                  i_host_mem_select_n, i_host_io_read_n,
                  i_host_io_write_n, i_host_addr_enable,
                  i_shared_memory_strap, i_host_reset_mode_strap,
                  i_host_device_enable_strap, i_host_addr,
                  i_host_data}),
    .o_sync     (sv)
  );

  assign {s_mrd_n, s_mwr_n, s_mcs_n, s_ior_n, s_iow_n, s_aen,
          s_shared_memory_strap, s_host_reset_mode_strap, s_host_device_enable_strap, s_addr, s_data} = sv;

  // A strobe counts only together with its select.
  function automatic logic is_cmd(input logic sel_n, input logic stb_n);
    is_cmd = !sel_n && !stb_n;
  endfunction

  // Byte lane for an 8-bit host transfer on the 16-bit memory.
  function automatic logic [1:0] lane(input logic a0);
    lane = a0 ? `LANE_HIGH : `LANE_LOW;
  endfunction

  // Memory strobes from the host and the gate for completing them.
  assign mem_cmd = is_cmd(s_mcs_n, s_mrd_n) ||
                   is_cmd(s_mcs_n, s_mwr_n);
  assign can_go = q.share_en && i_active_mode &&
                  i_shared_mem_enable && i_rom_shadow_off;
  assign host_addr_bit0 = q.addr[0];

  // I/O decode: address enable high marks a DMA cycle, not ours.
  assign h_idx = !s_aen && q.rtc_dev_en &&
                 (s_addr[15:0] == `RTC_INDEX_PORT);
  assign h_dat = !s_aen && q.rtc_dev_en &&
                 (s_addr[15:0] == `RTC_DATA_PORT);
  assign host_ok = !i_rtc_core_owner_lock;
  assign core_ok = i_rtc_core_owner_lock && i_active_mode;

  // One RTC port serves both sides; the ownership lock picks the writer.
  always_comb begin
    ram_we = 1'b0;
    ram_wdata = q.iodat;
    if (core_ok) begin
      ram_wdata = i_core_rtc_wdata;
      ram_we = i_core_rtc_wr && i_core_rtc_sel;
    end else if (host_ok) begin
      ram_we = s_iow_n && !q.iow_prev && q.io_dat;
    end
    if (q.cmos_lock && q.index[6:0] >= `CMOS_LOCK_BASE) begin
      ram_we = 1'b0;
    end
  end

  rtc_ram #(
    .AW (7),
    .DW (8)
  ) u_rtc_ram (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_we       (ram_we),
    .i_addr     (q.index[6:0]),
    .i_wdata    (ram_wdata),
    .o_rdata    (ram_rdata)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    d = q;
    d.iow_prev = s_iow_n;
    d.shadow = !i_rom_shadow_off;

    // Straps are taken once the synchroniser has filled after reset.
    if (!q.strap_done) begin
      d.cnt = q.cnt + 2'h1;
      if (q.cnt == `STRAP_WAIT) begin
        d.strap_done = 1'b1;
        d.share_en = (s_shared_memory_strap == `SHARE_ON_LEVEL);
        d.hrst_mode = s_host_reset_mode_strap;
        d.rtc_dev_en = (s_host_device_enable_strap == `DEV_ON_LEVEL);
      end
    end else if (i_rtc_dev_en_wr) begin
      d.rtc_dev_en = i_rtc_dev_en_val;
    end

    // Release wins, so firmware can always reopen the locked range.
    if (i_rtc_memory_release) begin
      d.cmos_lock = 1'b0;
    end else if (i_rtc_cmos_lock_set) begin
      d.cmos_lock = 1'b1;
    end

    // Shared-memory sequencer.
    case (q.st)
      hsm_bridge_pkg::S_IDLE,
      hsm_bridge_pkg::S_HOLD: begin
        if (q.share_en && mem_cmd) begin
          d.ready = 1'b0;
          d.addr = s_addr;
          d.be = lane(s_addr[0]);
          if (can_go) begin
            if (!s_mrd_n) begin
              d.st = hsm_bridge_pkg::S_RD_BUS;
              d.req = 1'b1;
            end else begin
              d.st = hsm_bridge_pkg::S_WR_CAPT;
            end
          end else if (q.hrst_mode) begin
            d.st = hsm_bridge_pkg::S_HRESET;
            d.rst_out_n = 1'b0;
            d.ready = 1'b1;
          end else begin
            d.st = hsm_bridge_pkg::S_HOLD;
          end
        end else begin
          d.st = hsm_bridge_pkg::S_IDLE;
          d.ready = 1'b1;
        end
      end
      hsm_bridge_pkg::S_RD_BUS: begin
        if (i_core_bus_gnt && i_mem_done) begin
          d.req = 1'b0;
          d.hdata = host_addr_bit0 ? i_mem_rdata[15:8]
                                   : i_mem_rdata[7:0];
          d.hoe = 1'b1;
          d.ready = 1'b1;
          d.st = hsm_bridge_pkg::S_RD_DRIVE;
        end
      end
      hsm_bridge_pkg::S_RD_DRIVE: begin
        if (s_mrd_n) begin
          d.hoe = 1'b0;
          d.st = hsm_bridge_pkg::S_IDLE;
        end
      end
      hsm_bridge_pkg::S_WR_CAPT: begin
        d.ready = 1'b1;
        if (!s_mwr_n) begin
          d.wbuf = s_data;
        end else begin
          d.st = hsm_bridge_pkg::S_WR_BUS;
          d.req = 1'b1;
          d.mwr = 1'b1;
        end
      end
      hsm_bridge_pkg::S_WR_BUS: begin
        if (i_core_bus_gnt && i_mem_done) begin
          d.req = 1'b0;
          d.mwr = 1'b0;
          d.st = hsm_bridge_pkg::S_IDLE;
        end
      end
      hsm_bridge_pkg::S_HRESET: begin
        if (s_mrd_n && s_mwr_n && can_go) begin
          d.rst_out_n = 1'b1;
          d.st = hsm_bridge_pkg::S_IDLE;
        end
      end
      default: begin
        d.st = hsm_bridge_pkg::S_IDLE;
      end
    endcase

    // Host I/O: address and data are held while the write strobe is
    // low and acted on at its trailing edge, when both are settled.
    if (!s_iow_n) begin
      d.iodat = s_data;
      d.io_idx = h_idx;
      d.io_dat = h_dat;
    end
    if (s_iow_n && !q.iow_prev && q.io_idx && host_ok) begin
      d.index = q.iodat;
    end

    // Host I/O read shares the data pins unless memory data is out.
    if (q.st != hsm_bridge_pkg::S_RD_DRIVE &&
        d.st != hsm_bridge_pkg::S_RD_DRIVE) begin
      d.hoe = !s_ior_n && (h_idx || h_dat);
      if (!host_ok) begin
        d.hdata = `BLOCKED_READ;
      end else begin
        d.hdata = h_idx ? q.index : ram_rdata;
      end
    end

    // Core side of the same index and data registers.
    if (i_core_rtc_wr && core_ok && !i_core_rtc_sel) begin
      d.index = i_core_rtc_wdata;
    end
    if (i_core_rtc_rd) begin
      if (!core_ok) begin
        d.crd = `BLOCKED_READ;
      end else begin
        d.crd = i_core_rtc_sel ? ram_rdata : q.index;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset keeps host reset inactive and the channel ready.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.st <= hsm_bridge_pkg::S_IDLE;
      q.ready <= 1'b1;
      q.rst_out_n <= 1'b1;
      q.iow_prev <= 1'b1;
      q.shadow <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs are the state register itself.
  assign o_host_data = q.hdata;
  assign o_host_data_oe = q.hoe;
  assign o_host_channel_ready = q.ready;
  assign o_host_reset_out_n = q.rst_out_n;
  assign o_rom_shadow_on = q.shadow;
  assign o_share_enabled = q.share_en;
  assign o_core_bus_req = q.req;
  assign o_mem_addr = q.addr;
  assign o_mem_be = q.be;
  assign o_mem_write = q.mwr;
  assign o_mem_wdata = {q.wbuf, q.wbuf};
  assign o_rtc_cmos_locked = q.cmos_lock;
  assign o_rtc_dev_enabled = q.rtc_dev_en;
  assign o_core_rtc_rdata = q.crd;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_cmd_seen;
    q.st == hsm_bridge_pkg::S_IDLE && q.share_en && mem_cmd;
  endsequence

  sequence s_blocked;
    !can_go && !q.hrst_mode;
  endsequence

  // Reset mode answers a blocked access with host reset, not a stretch.
  chk_ready_stretch: assert property (
    s_cmd_seen ##0 (can_go || !q.hrst_mode) |=> !o_host_channel_ready)
    else $error("Ready not pulled low on a host access.");

  chk_hrst_start: assert property (
    s_cmd_seen ##0 (!can_go && q.hrst_mode) |=>
      !o_host_reset_out_n && o_host_channel_ready)
    else $error("Blocked access did not raise host reset.");

  chk_hold_off: assert property (
    s_cmd_seen ##0 s_blocked |=> !o_host_channel_ready && !o_core_bus_req)
    else $error("Blocked access was not held off.");

  chk_req_gate: assert property (
    $rose(o_core_bus_req) && !o_mem_write |-> $past(can_go))
    else $error("Core bus requested while access may not complete.");

  chk_hrst_nomem: assert property (
    !o_host_reset_out_n |-> !o_core_bus_req && !o_mem_write)
    else $error("Memory cycle during host reset.");

  chk_hrst_end: assert property (
    $rose(o_host_reset_out_n) |-> $past(s_mrd_n && s_mwr_n && can_go))
    else $error("Host reset released too early.");

  chk_lane_pick: assert property (
    o_core_bus_req |-> o_mem_be == lane(o_mem_addr[0]))
    else $error("Byte lane does not follow address bit zero.");

  chk_write_late: assert property (
    $rose(o_mem_write) |-> $past(s_mwr_n) && o_host_channel_ready)
    else $error("Memory write started before host write ended.");

  chk_read_hold: assert property (
    q.st == hsm_bridge_pkg::S_RD_DRIVE && !s_mrd_n |=>
      o_host_data_oe [*2] or (s_mrd_n ##1 1'b1))
    else $error("Read data dropped while memory read active.");

  chk_core_block: assert property (
    i_core_rtc_wr && !i_core_rtc_sel && !core_ok && !i_rst |=>
      $stable(q.index) || $past(s_iow_n && !q.iow_prev))
    else $error("Core index write not ignored without lock.");

  chk_release: assert property (
    i_rtc_memory_release |=> !o_rtc_cmos_locked)
    else $error("CMOS lock not cleared by release.");
endmodule
`default_nettype wire

// ===== hdl/hsm_bridge_defines.svh
// What this block does
// - Host side is 8-bit ISA; memory and I/O strobes are both answered.
// - Host and core accesses to shared memory and RTC are arbitrated.
// - Shared-memory strap caught after reset; low enables sharing.
// - Host memory read or write with select requests the core bus.
// - Channel ready is held low while a shared-memory read runs; a write that can complete drops it for one cycle only.
// - Access completes only in active mode with share-enable and shadow-off set.
// - Reset-mode strap low: an access that cannot complete waits on ready.
// - Reset-mode strap high: such an access pulls host reset, no memory cycle.
// - Host reset ends once both memory strobes are high and access can complete.
// - Host address bit zero steers the byte to the low or high memory lane.
// - Host write data is buffered; memory write starts after the host cycle.
// - Core index and data registers are the host's ports 0070h and 0071h.
// - Ownership lock clear: host proceeds, core writes ignored, core reads junk.
// - Ownership lock set: core proceeds, host writes ignored, host reads junk.
// - Core reaches the RTC only in active mode and under the ownership lock.
// - Memory-release control clears the CMOS lock bits.
// - Shadow ROM window is open until shadow-off is set.
// - Device-enable strap picks the RTC channel's enable after reset.
`ifndef HSM_BRIDGE_DEFINES_SVH
`define HSM_BRIDGE_DEFINES_SVH
`define RTC_INDEX_PORT 16'h0070
`define RTC_DATA_PORT 16'h0071
`define BLOCKED_READ 8'hFF
`define CMOS_LOCK_BASE 7'h0E
`define SHARE_ON_LEVEL 1'b0
`define DEV_ON_LEVEL 1'b1
`define STRAP_WAIT 2'h3
`define LANE_LOW 2'h1
`define LANE_HIGH 2'h2
`endif

// ===== hdl/hsm_bridge_pkg.sv
package hsm_bridge_pkg;
  // Host shared-memory access sequencer.
  typedef enum logic [2:0] {
    S_IDLE,
    S_HOLD,
    S_RD_BUS,
    S_RD_DRIVE,
    S_WR_CAPT,
    S_WR_BUS,
    S_HRESET
  } mem_state_type;
endpackage

// ===== hdl/bit_sync.sv
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("bit_sync width must be positive.");
    end
  endgenerate

  // The first stage feeds only the second one.
  always_comb begin
    d.meta = i_async;
    d.sync = q.meta;
  end

  // Resets to all ones so active-low strobes start idle.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.sync;
endmodule
`default_nettype wire

// ===== hdl/rtc_ram.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rdata;
  } ram_state_type;

  ram_state_type q;
  ram_state_type d;

  generate
    if (AW < 1 || AW > 8 || DW < 1) begin : g_bad
      $error("rtc_ram size out of range.");
    end
  endgenerate

  // Read data is registered, so it trails the address by one cycle.
  always_comb begin
    d = q;
    if (i_we) begin
      d.mem[i_addr] = i_wdata;
    end
    d.rdata = q.mem[i_addr];
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
endmodule
`default_nettype wire

// ===== dv/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Host chipset stand-in
// ****
module host_bus_model (
  input  wire logic        i_core_clk,
  input  wire logic [7:0]  i_dev_data,
  input  wire logic        i_dev_oe,
  input  wire logic        i_ready,
  output logic             o_mem_read_n,
  output logic             o_mem_write_n,
  output logic             o_mem_select_n,
  output logic             o_io_read_n,
  output logic             o_io_write_n,
  output logic             o_addr_enable,
  output logic [19:0]      o_addr,
  output logic [7:0]       o_data,
  output logic             o_timeout
);
  logic       drv;
  logic [7:0] dat;
  logic [7:0] flt;

  // Undriven data lines flip every cycle, so a stale byte never passes.
  always @(posedge i_core_clk) begin
    flt <= ~flt;
  end
  assign o_data = drv ? dat : (i_dev_oe ? i_dev_data : flt);

  // The bus is idle, all strobes high, until a cycle is started.
  initial begin
    {o_mem_read_n, o_mem_write_n, o_mem_select_n} = 3'h7;
    {o_io_read_n, o_io_write_n, o_addr_enable} = 3'h7;
    {drv, dat, flt, o_addr, o_timeout} = {1'b0, 8'h00, 8'h96, 21'h0};
  end

  // One 8-bit cycle, held until ready is seen high at a rising edge.
  task automatic cyc(input logic io, input logic wr,
                     input logic [19:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    @(negedge i_core_clk);
    o_addr = a;
    dat = wd;
    drv = wr;
    o_addr_enable = 1'b0;
    o_mem_select_n = io;
    o_mem_read_n = io | wr;
    o_mem_write_n = io | !wr;
    o_io_read_n = !io | wr;
    o_io_write_n = !io | !wr;
    n = 0;
    repeat (6) @(posedge i_core_clk);
    while (i_ready !== 1'b1 && n < 400) begin
      @(posedge i_core_clk);
      n++;
    end
    rd = o_data;
    o_timeout = (n >= 400);
    @(negedge i_core_clk);
    {o_mem_read_n, o_mem_write_n, o_mem_select_n} = 3'h7;
    {o_io_read_n, o_io_write_n, o_addr_enable} = 3'h7;
    drv = 1'b0;
    repeat (4) @(negedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bridge bench
// ****
module tb_top;
  logic        clk, rst, mrn, mwn, msn, irn, iwn, aen, tmo, lo, early;
  logic        oe, rdy, hrn, shon, shen, req, gnt, done, mw, gw;
  logic        ssh, srm, host_device_enable_strap, act, en, soff, lk, rel, lset, cml;
  logic        dwr, dval, denb, cwr, crd, csel;
  logic [19:0] addr, maddr, ga;
  logic [15:0] wd, gwd, mrd;
  logic [7:0]  hd, dout, rd, cwd, crdat;
  logic [1:0]  be, gbe;
  int          n_req, err_count, n_compared;

  host_shared_memory_bridge u_dut (
    .i_core_clk(clk), .i_rst(rst),
    .i_host_mem_read_n(mrn), .i_host_mem_write_n(mwn),
    .i_host_mem_select_n(msn), .i_host_io_read_n(irn),
    .i_host_io_write_n(iwn), .i_host_addr_enable(aen),
    .i_host_addr(addr), .i_host_data(hd), .o_host_data(dout),
    .o_host_data_oe(oe), .o_host_channel_ready(rdy),
    .o_host_reset_out_n(hrn), .i_shared_memory_strap(ssh),
    .i_host_reset_mode_strap(srm), .i_host_device_enable_strap(host_device_enable_strap),
    .i_active_mode(act), .i_shared_mem_enable(en),
    .i_rom_shadow_off(soff), .o_rom_shadow_on(shon),
    .o_share_enabled(shen), .o_core_bus_req(req),
    .i_core_bus_gnt(gnt), .i_mem_done(done), .i_mem_rdata(mrd),
    .o_mem_addr(maddr), .o_mem_be(be), .o_mem_write(mw),
    .o_mem_wdata(wd), .i_rtc_core_owner_lock(lk),
    .i_rtc_memory_release(rel), .i_rtc_cmos_lock_set(lset),
    .o_rtc_cmos_locked(cml), .i_rtc_dev_en_wr(dwr),
    .i_rtc_dev_en_val(dval), .o_rtc_dev_enabled(denb),
    .i_core_rtc_wr(cwr), .i_core_rtc_rd(crd), .i_core_rtc_sel(csel),
    .i_core_rtc_wdata(cwd), .o_core_rtc_rdata(crdat)
  );

  host_bus_model u_host (
    .i_core_clk(clk), .i_dev_data(dout), .i_dev_oe(oe), .i_ready(rdy),
    .o_mem_read_n(mrn), .o_mem_write_n(mwn), .o_mem_select_n(msn),
    .o_io_read_n(irn), .o_io_write_n(iwn), .o_addr_enable(aen),
    .o_addr(addr), .o_data(hd), .o_timeout(tmo)
  );

  // Core clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Core bus stand-in: grants, with done, at the same falling edge that sees a request.
  always @(negedge clk) begin
    gnt = req && !gnt;
    done = gnt;
    if (gnt) begin
      {ga, gbe, gw, gwd} = {maddr, be, mw, wd};
      n_req++;
    end
  end

  // Notes a stretch, and any memory request while a host write runs.
  always @(posedge clk) begin
    if (rdy === 1'b0) lo = 1'b1;
    if (!mwn && req === 1'b1) early = 1'b1;
  end

  // A host cycle that never sees ready ends the run.
  always @(posedge tmo) begin
    err_count++;
    test_done();
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Straps are held from reset on, well past their sampling edge.
  task automatic do_reset(input logic sh, input logic rm);
    @(negedge clk);
    rst = 1'b1;
    ssh = sh;
    srm = rm;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic hc(input logic io, input logic wr,
                    input logic [19:0] a, input logic [7:0] d);
    u_host.cyc(io, wr, a, d, rd);
  endtask

  // A core RTC access: one-cycle strobe, answer read after it.
  task automatic core(input logic w, input logic s, input logic [7:0] d);
    @(negedge clk);
    {cwr, crd, csel, cwd} = {w, !w, s, d};
    @(negedge clk);
    {cwr, crd} = 2'h0;
    @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask

  task automatic t_read();
    for (int i = 0; i < 2; i++) begin
      lo = 1'b0;
      hc(1'b0, 1'b0, 20'h01230 + 20'(i), 8'h00);
      chk(16'(lo), 16'h1);
      chk(16'(rd), i ? 16'h00A5 : 16'h005A);
      chk(16'(gbe), 16'(i + 1));
      chk(ga[15:0], 16'h1230 + 16'(i));
      chk(16'({oe, gw}), 16'h0);
    end
  endtask

  task automatic t_write();
    early = 1'b0;
    hc(1'b0, 1'b1, 20'h04567, 8'h3C);
    repeat (4) @(negedge clk);
    chk(16'(early), 16'h0);
    chk(gwd, 16'h3C3C);
    chk(16'({gw, gbe}), 16'h6);
  endtask

  // Each completion condition is dropped in turn; the read must wait.
  task automatic t_hold();
    for (int k = 0; k < 3; k++) begin
      {act, en, soff} = 3'h7 ^ (3'h4 >> k);
      fork
        hc(1'b0, 1'b0, 20'h00010, 8'h00);
        begin
          repeat (40) @(negedge clk);
          chk(16'({rdy,req,shon}), 16'(k==2));
          {act, en, soff} = 3'h7;
        end
      join
      chk(16'(rd), 16'h005A);
    end
  endtask

  task automatic t_rtc();
    chk(16'(denb), 16'h1);
    hc(1'b1, 1'b1, 20'h00070, 8'h20);
    hc(1'b1, 1'b1, 20'h00071, 8'h5A);
    core(1'b1, 1'b1, 8'h11);
    core(1'b1, 1'b0, 8'h33);
    core(1'b0, 1'b1, 8'h00);
    chk(16'(crdat), 16'h00FF);
    hc(1'b1, 1'b0, 20'h00071, 8'h00);
    chk(16'(rd), 16'h005A);
    lk = 1'b1;
    hc(1'b1, 1'b1, 20'h00071, 8'h77);
    hc(1'b1, 1'b0, 20'h00071, 8'h00);
    chk(16'(rd), 16'h00FF);
    act = 1'b0;
    core(1'b1, 1'b1, 8'h99);
    act = 1'b1;
    core(1'b0, 1'b1, 8'h00);
    chk(16'(crdat), 16'h005A);
    core(1'b1, 1'b0, 8'h0E);
    pulse(lset);
    chk(16'(cml), 16'h1);
    pulse(rel);
    chk(16'(cml), 16'h0);
    core(1'b1, 1'b1, 8'h55);
    pulse(lset);
    core(1'b1, 1'b1, 8'h44);
    core(1'b0, 1'b1, 8'h00);
    chk(16'(crdat), 16'h0055);
    lk = 1'b0;
    dval = 1'b0;
    pulse(dwr);
    chk(16'(denb), 16'h0);
  endtask

  task automatic t_hreset();
    int n0;
    host_device_enable_strap = 1'b0;
    do_reset(1'b1, 1'b0);
    chk(16'(denb), 16'h0);
    host_device_enable_strap = 1'b1;
    n0 = n_req;
    lo = 1'b0;
    hc(1'b0, 1'b0, 20'h00020, 8'h00);
    chk(16'({shen, lo}), 16'h0);
    do_reset(1'b0, 1'b1);
    soff = 1'b0;
    hc(1'b0, 1'b0, 20'h00020, 8'h00);
    chk(16'({hrn, rdy}), 16'h1);
    chk(16'(n_req - n0), 16'h0);
    soff = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'(hrn), 16'h1);
  endtask

  // Main sequence.
  initial begin
    {act, en, soff, lk, rel, lset, dwr, dval} = 8'hE1;
    {cwr, crd, csel, gnt, done, ssh, srm, rst} = 8'h01;
    {lo, early, host_device_enable_strap, cwd, mrd} = {3'h1, 8'h00, 16'hA55A};
    {n_req, err_count, n_compared} = {32'd0, 32'd0, 32'd0};
    do_reset(1'b0, 1'b0);
    chk(16'(shen), 16'h1);
    t_read();
    t_write();
    t_hold();
    t_rtc();
    t_hreset();
    test_done();
  end
endmodule
`default_nettype wire
